// *** rtl/colour_palette_lookup.sv ***
/*
 * Sixteen-entry colour palette: host byte port on one side, pixel stream on the other.
 * Assumes every pin is synchronous to mclk; dot clock and strobes are sampled as levels.
 */
`timescale 1ns/1ps
// Function
// - Table of 16 entries, each three 4-bit colour fields plus a marking bit.
// - Mode pin high selects indirect non-multiplexed bus; low selects multiplexed bus.
// - Non-multiplexed: address strobe high picks address register, low picks data register.
// - Multiplexed: address strobe fall captures address byte, data strobe and selects.
// - Captured data strobe level chooses clocked-strobe or split read/write protocol.
// - Non-multiplexed: data strobe high enables bus drivers and moves data.
// - Direction input high means read, low means write; in split style it is an active-low write strobe.
// - Selected only while low select is low and high select is high.
// - Non-multiplexed selection follows the select pins live.
// - Multiplexed selection is latched at address strobe and governs the access.
// - Dot clock rise captures index and blanking and loads output registers.
// - Captured four index bits choose the palette entry read out.
// - Marking output is registered on the dot clock from selected entry.
// - Colour codes appear exactly one dot clock period after index capture.
// - Blanking high forces all colour outputs and marking output low.
// - Active-high reset forces outputs low until the next host access.
// - Each 4-bit code is unsigned; zero lowest level, all ones highest.
// - Entry N is byte 2N (fields one, two) and byte 2N+1 (three, mark).
// - Non-multiplexed address register is 5 bits, writable, not readable.
// - Every non-multiplexed data register access advances the address by one modulo 32.
// - While the host selects the device, all colour and marking outputs are low.
module colour_palette_lookup #(
	parameter int N_ENTRIES = palette_pkg::ENTRIES,
	parameter int WBUF_DEPTH = palette_pkg::BUF_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic bus_style_pin,
	input wire logic addr_sel_strobe,
	input wire logic data_strobe_in,
	input wire logic direction_in,
	input wire logic chip_sel_low,
	input wire logic chip_sel_high,
	input wire palette_pkg::byte_t shared_bus_in,
	output palette_pkg::byte_t shared_bus_out,
	output logic shared_bus_oe,
	output logic host_busy,
	input wire logic palette_reset,
	input wire logic dot_clock_in,
	input wire palette_pkg::index_t colour_index_in,
	input wire logic blanking_in,
	output palette_pkg::code_t chan_one_out,
	output palette_pkg::code_t chan_two_out,
	output palette_pkg::code_t chan_three_out,
	output logic inlay_flag
);
	import palette_pkg::*;

	if (N_ENTRIES != ENTRIES) begin : g_bad_entries
		$error("colour_palette_lookup: N_ENTRIES must be 16 to fill the 5-bit byte space");
	end

	// ----------------------------------------------------------------
	// Byte view of an entry
	// ----------------------------------------------------------------
	function automatic byte_t entry_byte(input entry_t e, input logic odd);
		byte_t b;
		b = BYTE_RST;
		if (odd) begin
			b[ODD_CH3_LSB +: FIELD_W] = e[CH3_LSB +: FIELD_W];
			b[ODD_MARK_POS] = e[MARK_POS];
		end else begin
			b[EVEN_CH1_LSB +: FIELD_W] = e[CH1_LSB +: FIELD_W];
			b[EVEN_CH2_LSB +: FIELD_W] = e[CH2_LSB +: FIELD_W];
		end
		return b;
	endfunction : entry_byte

	function automatic entry_t merge_byte(input entry_t e, input logic odd, input byte_t b);
		entry_t r;
		r = e;
		if (odd) begin
			r[CH3_LSB +: FIELD_W] = b[ODD_CH3_LSB +: FIELD_W];
			r[MARK_POS] = b[ODD_MARK_POS];
		end else begin
			r[CH1_LSB +: FIELD_W] = b[EVEN_CH1_LSB +: FIELD_W];
			r[CH2_LSB +: FIELD_W] = b[EVEN_CH2_LSB +: FIELD_W];
		end
		return r;
	endfunction : merge_byte

	// ----------------------------------------------------------------
	// Pin sampling and edge detection
	// ----------------------------------------------------------------
	logic as_prev_r;
	logic ds_prev_r;
	logic dir_prev_r;
	logic dot_prev_r;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			as_prev_r <= 1'b0;
			ds_prev_r <= 1'b0;
			dir_prev_r <= 1'b1;
			dot_prev_r <= 1'b0;
		end else begin
			as_prev_r <= addr_sel_strobe;
			ds_prev_r <= data_strobe_in;
			dir_prev_r <= direction_in;
			dot_prev_r <= dot_clock_in;
		end
	end

	logic as_fall;
	logic ds_rise;
	logic ds_fall;
	logic dir_rise;
	logic dot_rise;
	logic nonmux;
	logic sel_live;

	assign as_fall = as_prev_r && !addr_sel_strobe;
	assign ds_rise = !ds_prev_r && data_strobe_in;
	assign ds_fall = ds_prev_r && !data_strobe_in;
	assign dir_rise = !dir_prev_r && direction_in;
	assign dot_rise = !dot_prev_r && dot_clock_in;
	assign nonmux = bus_style_pin;
	assign sel_live = !chip_sel_low && chip_sel_high;

	// ----------------------------------------------------------------
	// Multiplexed-mode address phase
	// ----------------------------------------------------------------
	mx_style_e mx_style_r;
	logic cs_lat_r;
	logic mx_strobe;

	assign mx_strobe = !nonmux && as_fall;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mx_style_r <= MX_IDLE;
			cs_lat_r <= 1'b0;
		end else if (nonmux) begin
			mx_style_r <= MX_IDLE;
			cs_lat_r <= 1'b0;
		end else if (mx_strobe) begin
			cs_lat_r <= sel_live;
			mx_style_r <= data_strobe_in ? MX_SPLIT : MX_CLOCKED;
		end
	end

	logic selected;

	assign selected = nonmux ? sel_live : cs_lat_r;

	// ----------------------------------------------------------------
	// Access events, one cycle each except rd_end, which stays high while deselected in MX_IDLE
	// ----------------------------------------------------------------
	logic nm_addr_wr;
	logic rd_start;
	logic rd_end;
	logic wr_go;
	logic nm_data_acc;
	logic host_access;

	// In split style the data strobe is an active-low read and the direction pin an active-low write
	always_comb begin
		rd_start = 1'b0;
		rd_end = 1'b0;
		wr_go = 1'b0;
		unique case (mx_style_r)
			MX_IDLE: begin
				rd_start = nonmux && sel_live && ds_rise && !addr_sel_strobe && direction_in;
				rd_end = ds_fall || !sel_live;
				wr_go = nonmux && sel_live && ds_rise && !addr_sel_strobe && !direction_in;
			end
			MX_CLOCKED: begin
				rd_start = cs_lat_r && ds_rise && direction_in;
				rd_end = ds_fall;
				wr_go = cs_lat_r && ds_fall && !direction_in;
			end
			MX_SPLIT: begin
				rd_start = cs_lat_r && ds_fall;
				rd_end = ds_rise;
				wr_go = cs_lat_r && dir_rise;
			end
		endcase
	end

	assign nm_addr_wr = nonmux && sel_live && ds_rise && addr_sel_strobe && !direction_in;
	assign nm_data_acc = nonmux && (rd_start || wr_go);
	assign host_access = nm_addr_wr || rd_start || wr_go;

	// ----------------------------------------------------------------
	// Byte address register
	// ----------------------------------------------------------------
	byte_addr_t addr_r;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_r <= ADDR_RST;
		end else if (mx_strobe) begin
			addr_r <= shared_bus_in[ADDR_W-1:0];
		end else if (nm_addr_wr) begin
			addr_r <= shared_bus_in[ADDR_W-1:0];
		end else if (nm_data_acc) begin
			addr_r <= addr_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Write buffer and table
	// ----------------------------------------------------------------
	wbuf_if wq ();
	logic dot_fetch;

	assign dot_fetch = dot_rise;
	assign wq.in_valid = wr_go;
	assign wq.in_data = '{addr: addr_r, data: shared_bus_in};
	// Video fetch owns the table port; host writes wait in the buffer
	assign wq.out_ready = !dot_fetch;
	assign host_busy = !wq.in_ready;

	write_buffer #(
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.mclk(mclk),
		.rst_n(rst_n),
		.bus(wq)
	);

	entry_t table_r [N_ENTRIES];
	logic wq_pop;
	index_t pop_entry;

	assign wq_pop = wq.out_valid && wq.out_ready;
	assign pop_entry = wq.out_data.addr[ADDR_W-1:1];

	for (genvar i = 0; i < N_ENTRIES; i++) begin : g_entry
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				table_r[i] <= ENTRY_RST;
			end else if (wq_pop && pop_entry == INDEX_W'(i)) begin
				table_r[i] <= merge_byte(table_r[i], wq.out_data.addr[0], wq.out_data.data);
			end
		end
	end

	// ----------------------------------------------------------------
	// Host read path
	// ----------------------------------------------------------------
	// A read right behind a write may see the old byte while the write still waits
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shared_bus_out <= BYTE_RST;
			shared_bus_oe <= 1'b0;
		end else if (rd_start) begin
			shared_bus_out <= entry_byte(table_r[addr_r[ADDR_W-1:1]], addr_r[0]);
			shared_bus_oe <= 1'b1;
		end else if (rd_end) begin
			shared_bus_oe <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Video path
	// ----------------------------------------------------------------
	index_t idx_r;
	logic blank_r;
	logic hold_black_r;
	entry_t cur_entry;

	assign cur_entry = table_r[idx_r];

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			idx_r <= '0;
			blank_r <= 1'b1;
		end else if (dot_rise) begin
			idx_r <= colour_index_in;
			blank_r <= blanking_in;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hold_black_r <= 1'b1;
		end else if (palette_reset) begin
			hold_black_r <= 1'b1;
		end else if (host_access) begin
			hold_black_r <= 1'b0;
		end
	end

	logic force_low;

	assign force_low = selected || hold_black_r || palette_reset;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chan_one_out <= CODE_LOW;
			chan_two_out <= CODE_LOW;
			chan_three_out <= CODE_LOW;
			inlay_flag <= 1'b0;
		end else if (force_low) begin
			chan_one_out <= CODE_LOW;
			chan_two_out <= CODE_LOW;
			chan_three_out <= CODE_LOW;
			inlay_flag <= 1'b0;
		end else if (dot_rise) begin
			chan_one_out <= blank_r ? CODE_LOW : cur_entry[CH1_LSB +: FIELD_W];
			chan_two_out <= blank_r ? CODE_LOW : cur_entry[CH2_LSB +: FIELD_W];
			chan_three_out <= blank_r ? CODE_LOW : cur_entry[CH3_LSB +: FIELD_W];
			inlay_flag <= blank_r ? 1'b0 : cur_entry[MARK_POS];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic outs_low;
	logic live_fetch;

	assign outs_low = chan_one_out == CODE_LOW && chan_two_out == CODE_LOW
		&& chan_three_out == CODE_LOW && !inlay_flag;
	assign live_fetch = dot_rise && !blank_r && !force_low;

	property p_pixel_latency;
		live_fetch |=> chan_one_out == $past(cur_entry[CH1_LSB +: FIELD_W])
			&& chan_two_out == $past(cur_entry[CH2_LSB +: FIELD_W])
			&& chan_three_out == $past(cur_entry[CH3_LSB +: FIELD_W]);
	endproperty
	a_pixel_latency: assert property (p_pixel_latency) else $error("colour codes wrong");

	property p_mark_out;
		live_fetch |=> inlay_flag == $past(cur_entry[MARK_POS]);
	endproperty
	a_mark_out: assert property (p_mark_out) else $error("marking output wrong");

	property p_index_capture;
		dot_rise |=> idx_r == $past(colour_index_in) && blank_r == $past(blanking_in);
	endproperty
	a_index_capture: assert property (p_index_capture) else $error("index not captured");

	property p_blank_low;
		dot_rise && blank_r |=> outs_low;
	endproperty
	a_blank_low: assert property (p_blank_low) else $error("blanking not applied");

	property p_select_low;
		selected |=> outs_low;
	endproperty
	a_select_low: assert property (p_select_low) else $error("outputs live while selected");

	property p_reset_hold;
		palette_reset ##1 !host_access [*3] |=> outs_low && hold_black_r;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("reset black not held");

	property p_auto_inc;
		nm_data_acc |=> addr_r == $past(addr_r) + 5'h01;
	endproperty
	a_auto_inc: assert property (p_auto_inc) else $error("address did not advance");

	property p_addr_load;
		nm_addr_wr |=> addr_r == $past(shared_bus_in[ADDR_W-1:0]);
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("address register not loaded");

	property p_mux_capture;
		mx_strobe |=> addr_r == $past(shared_bus_in[ADDR_W-1:0]) && cs_lat_r == $past(sel_live)
			&& mx_style_r == ($past(data_strobe_in) ? MX_SPLIT : MX_CLOCKED);
	endproperty
	a_mux_capture: assert property (p_mux_capture) else $error("address phase not latched");

	property p_table_write;
		wq_pop |=> entry_byte(table_r[$past(pop_entry)], $past(wq.out_data.addr[0]))
			== ($past(wq.out_data.addr[0]) ? ($past(wq.out_data.data) & 8'h1F) : $past(wq.out_data.data));
	endproperty
	a_table_write: assert property (p_table_write) else $error("table byte not stored");

	property p_read_drive;
		rd_start |=> shared_bus_oe
			##0 shared_bus_out == $past(entry_byte(table_r[addr_r[ADDR_W-1:1]], addr_r[0]));
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read byte not driven");

	property p_cov_split_write;
		mx_style_r == MX_SPLIT && wr_go;
	endproperty
	c_split_write: cover property (p_cov_split_write);

	property p_cov_seq_load;
		nm_data_acc ##[1:20] nm_data_acc;
	endproperty
	c_seq_load: cover property (p_cov_seq_load);

	property p_cov_buf_full;
		host_busy;
	endproperty
	c_buf_full: cover property (p_cov_buf_full);

	property p_cov_pixel;
		live_fetch ##1 inlay_flag;
	endproperty
	c_pixel: cover property (p_cov_pixel);

endmodule : colour_palette_lookup

// *** rtl/palette_pkg.sv ***
/*
 * Shared constants and types for the colour palette lookup block.
 * Assumes a single 100 MHz clock; all pins arrive already synchronous to it.
 */
package palette_pkg;

	// ----------------------------------------------------------------
	// Table geometry
	// ----------------------------------------------------------------
	localparam int ENTRIES = 16;
	localparam int FIELD_W = 4;
	localparam int ENTRY_W = 13;
	localparam int ADDR_W = 5;
	localparam int INDEX_W = 4;
	localparam int BYTE_W = 8;
	localparam int BUF_DEPTH = 2;

	// ----------------------------------------------------------------
	// Field positions inside an entry and inside the two host bytes
	// ----------------------------------------------------------------
	localparam int CH1_LSB = 0;
	localparam int CH2_LSB = 4;
	localparam int CH3_LSB = 8;
	localparam int MARK_POS = 12;
	localparam int EVEN_CH1_LSB = 0;
	localparam int EVEN_CH2_LSB = 4;
	localparam int ODD_CH3_LSB = 0;
	localparam int ODD_MARK_POS = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [ENTRY_W-1:0] ENTRY_RST = 13'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
	localparam logic [FIELD_W-1:0] CODE_LOW = 4'h0;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

	typedef logic [ENTRY_W-1:0] entry_t;
	typedef logic [ADDR_W-1:0] byte_addr_t;
	typedef logic [BYTE_W-1:0] byte_t;
	typedef logic [FIELD_W-1:0] code_t;
	typedef logic [INDEX_W-1:0] index_t;

	typedef struct packed {
		byte_addr_t addr;
		byte_t data;
	} wr_req_s;

	// Strobe style found at the last address strobe in multiplexed mode
	typedef enum {
		MX_IDLE,
		MX_CLOCKED,
		MX_SPLIT
	} mx_style_e;

endpackage : palette_pkg

// *** rtl/wbuf_if.sv ***
/*
 * Valid/ready carrier between the host write path and the write buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface wbuf_if;
	import palette_pkg::*;

	logic in_valid;
	logic in_ready;
	wr_req_s in_data;
	logic out_valid;
	logic out_ready;
	wr_req_s out_data;

	modport store (
		input in_valid,
		input in_data,
		input out_ready,
		output in_ready,
		output out_valid,
		output out_data
	);

	modport user (
		output in_valid,
		output in_data,
		output out_ready,
		input in_ready,
		input out_valid,
		input out_data
	);
endinterface : wbuf_if

// *** rtl/write_buffer.sv ***
/*
 * Small valid/ready FIFO holding host write requests until the table port is free.
 * Assumes the drain side may stall; full and empty are exact.
 */
`timescale 1ns/1ps
module write_buffer #(
	parameter int DEPTH = palette_pkg::BUF_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	wbuf_if.store bus
);
	import palette_pkg::*;

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("write_buffer: DEPTH must be a power of two, at least 2");
	end

	wr_req_s mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [PTR_W:0] count_r;
	logic push;
	logic pop;

	assign bus.in_ready = (count_r != (PTR_W+1)'(DEPTH));
	assign bus.out_valid = (count_r != '0);
	assign bus.out_data = mem_r[rd_ptr_r];
	assign push = bus.in_valid && bus.in_ready;
	assign pop = bus.out_valid && bus.out_ready;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

	// Storage needs no reset; count_r keeps stale words unreadable
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= bus.in_data;
		end
	end

endmodule : write_buffer

// *** testbench/host_video_model.sv ***
/*
 * Far-side model: host processor bus pins and the display controller pixel stream.
 * Assumes the bench resolves the shared bus and hands the resolved byte back as bus_seen.
 */
`timescale 1ns/1ps
module host_video_model (
	input wire logic mclk,
	input wire palette_pkg::byte_t bus_seen,
	output logic bus_style_pin,
	output logic addr_sel_strobe,
	output logic data_strobe_in,
	output logic direction_in,
	output logic chip_sel_low,
	output logic chip_sel_high,
	output palette_pkg::byte_t host_drv,
	output logic dot_clock_in,
	output palette_pkg::index_t colour_index_in,
	output logic blanking_in
);
	import palette_pkg::*;
	initial begin
		bus_style_pin = 1'b1;
		addr_sel_strobe = 1'b0;
		data_strobe_in = 1'b0;
		direction_in = 1'b0;
		chip_sel_low = 1'b1;
		chip_sel_high = 1'b0;
		host_drv = 8'h00;
		dot_clock_in = 1'b0;
		colour_index_in = 4'h0;
		blanking_in = 1'b0;
	end
	// ----------------------------------------------------------------
	// Host and pixel cycles
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic sel(input logic l, input logic h);
		@(posedge mclk);
		chip_sel_low <= l;
		chip_sel_high <= h;
		cyc(2);
	endtask : sel
	task automatic nm_acc(input logic rs, input logic rd, input byte_t d, output byte_t q);
		@(posedge mclk);
		bus_style_pin <= 1'b1;
		addr_sel_strobe <= rs;
		direction_in <= rd;
		chip_sel_low <= 1'b0;
		chip_sel_high <= 1'b1;
		host_drv <= d;
		@(posedge mclk);
		data_strobe_in <= 1'b1;
		cyc(3);
		q = bus_seen;
		data_strobe_in <= 1'b0;
		chip_sel_low <= 1'b1;
		// Released bus shows the inverse so a stale value never passes
		host_drv <= ~d;
		cyc(3);
	endtask : nm_acc
	task automatic mx_acc(input logic split, input logic rd, input byte_t a, input byte_t d,
		output byte_t q);
		@(posedge mclk);
		bus_style_pin <= 1'b0;
		chip_sel_low <= 1'b0;
		chip_sel_high <= 1'b1;
		addr_sel_strobe <= 1'b1;
		data_strobe_in <= split;
		direction_in <= split | rd;
		host_drv <= a;
		cyc(2);
		addr_sel_strobe <= 1'b0;
		cyc(2);
		// Pins let go: only the latched select may govern the data phase
		chip_sel_low <= 1'b1;
		host_drv <= d;
		if (!split) data_strobe_in <= 1'b1;
		else if (rd) data_strobe_in <= 1'b0;
		else direction_in <= 1'b0;
		cyc(3);
		q = bus_seen;
		data_strobe_in <= split;
		direction_in <= split | rd;
		cyc(2);
		host_drv <= ~d;
		addr_sel_strobe <= 1'b1;
		cyc(2);
		addr_sel_strobe <= 1'b0;
		cyc(2);
	endtask : mx_acc
	task automatic pixel(input index_t i, input logic b);
		@(posedge mclk);
		dot_clock_in <= 1'b0;
		colour_index_in <= i;
		blanking_in <= b;
		cyc(2);
		dot_clock_in <= 1'b1;
		cyc(3);
	endtask : pixel
endmodule : host_video_model

// *** testbench/test_colour_palette_lookup.sv ***
/*
 * Self-checking bench for the colour palette lookup block.
 * Assumes the model drives every pin except the clock, reset and the palette reset.
 */
`timescale 1ns/1ps
module test_colour_palette_lookup;
	import palette_pkg::*;
	logic mclk, rst_n, palette_reset, bus_style_pin, addr_sel_strobe, data_strobe_in;
	logic direction_in, chip_sel_low, chip_sel_high, dot_clock_in, blanking_in;
	logic shared_bus_oe, host_busy, inlay_flag;
	byte_t host_drv, bus_seen, shared_bus_out, q;
	index_t colour_index_in;
	code_t chan_one_out, chan_two_out, chan_three_out;
	byte_t exp_b [32];
	int mismatches = 0;
	int n_compared = 0;
	assign bus_seen = shared_bus_oe ? shared_bus_out : host_drv;
	colour_palette_lookup dut_u (.mclk(mclk), .rst_n(rst_n), .bus_style_pin(bus_style_pin),
		.addr_sel_strobe(addr_sel_strobe), .data_strobe_in(data_strobe_in),
		.direction_in(direction_in), .chip_sel_low(chip_sel_low),
		.chip_sel_high(chip_sel_high), .shared_bus_in(bus_seen),
		.shared_bus_out(shared_bus_out), .shared_bus_oe(shared_bus_oe), .host_busy(host_busy),
		.palette_reset(palette_reset), .dot_clock_in(dot_clock_in),
		.colour_index_in(colour_index_in), .blanking_in(blanking_in),
		.chan_one_out(chan_one_out), .chan_two_out(chan_two_out),
		.chan_three_out(chan_three_out), .inlay_flag(inlay_flag));
	host_video_model host_u (.mclk(mclk), .bus_seen(bus_seen), .bus_style_pin(bus_style_pin),
		.addr_sel_strobe(addr_sel_strobe), .data_strobe_in(data_strobe_in),
		.direction_in(direction_in), .chip_sel_low(chip_sel_low),
		.chip_sel_high(chip_sel_high), .host_drv(host_drv), .dot_clock_in(dot_clock_in),
		.colour_index_in(colour_index_in), .blanking_in(blanking_in));
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	task automatic chk(input byte_t got, input byte_t want);
		n_compared++;
		if (got !== want) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic vchk(input index_t i, input logic z);
		byte_t e, o;
		e = z ? 8'h00 : exp_b[{i, 1'b0}];
		o = z ? 8'h00 : exp_b[{i, 1'b1}];
		chk({4'h0, chan_one_out}, {4'h0, e[3:0]});
		chk({4'h0, chan_two_out}, {4'h0, e[7:4]});
		chk({4'h0, chan_three_out}, {4'h0, o[3:0]});
		chk({7'h00, inlay_flag}, {7'h00, o[4]});
	endtask : vchk
	task automatic pix2(input index_t i);
		host_u.pixel(i, 1'b0);
		host_u.pixel(i, 1'b0);
	endtask : pix2
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_load;
		host_u.nm_acc(1'b1, 1'b0, 8'h00, q);
		for (int n = 0; n < 33; n++) host_u.nm_acc(1'b0, 1'b0, exp_b[n % 32], q);
		host_u.nm_acc(1'b1, 1'b0, 8'hFE, q);
		for (int n = 30; n < 33; n++) begin
			host_u.nm_acc(1'b0, 1'b1, 8'h00, q);
			chk(q, exp_b[n % 32]);
			chk({7'h00, shared_bus_oe}, 8'h00);
		end
		// Address register is write-only: reading it must leave the bus undriven
		host_u.nm_acc(1'b1, 1'b1, 8'hA7, q);
		chk(q, 8'hA7);
		host_u.nm_acc(1'b0, 1'b1, 8'h00, q);
		chk(q, exp_b[1]);
		chk({7'h00, host_busy}, 8'h00);
		$display("test_load done");
	endtask : test_load
	task automatic test_video;
		host_u.pixel(4'h0, 1'b0);
		for (int n = 1; n <= 16; n++) begin
			host_u.pixel(index_t'(n), 1'b0);
			vchk(index_t'(n - 1), 1'b0);
		end
		$display("test_video done");
	endtask : test_video
	task automatic test_blank;
		host_u.pixel(4'h5, 1'b1);
		host_u.pixel(4'h6, 1'b0);
		vchk(4'h5, 1'b1);
		host_u.pixel(4'h7, 1'b0);
		vchk(4'h6, 1'b0);
		$display("test_blank done");
	endtask : test_blank
	task automatic test_select;
		host_u.sel(1'b0, 1'b0);
		pix2(4'h9);
		vchk(4'h9, 1'b0);
		host_u.sel(1'b0, 1'b1);
		pix2(4'h9);
		vchk(4'h9, 1'b1);
		host_u.sel(1'b1, 1'b1);
		pix2(4'h9);
		vchk(4'h9, 1'b0);
		host_u.sel(1'b1, 1'b0);
		$display("test_select done");
	endtask : test_select
	task automatic test_preset;
		@(posedge mclk);
		palette_reset <= 1'b1;
		repeat (2) @(posedge mclk);
		palette_reset <= 1'b0;
		pix2(4'h3);
		vchk(4'h3, 1'b1);
		host_u.nm_acc(1'b1, 1'b0, 8'h00, q);
		pix2(4'h3);
		vchk(4'h3, 1'b0);
		$display("test_preset done");
	endtask : test_preset
	task automatic test_mux;
		host_u.mx_acc(1'b0, 1'b0, 8'h04, 8'h5A, q);
		host_u.mx_acc(1'b0, 1'b1, 8'h04, 8'h00, q);
		chk(q, 8'h5A);
		host_u.mx_acc(1'b1, 1'b0, 8'hE5, 8'hFC, q);
		host_u.mx_acc(1'b1, 1'b1, 8'h05, 8'h00, q);
		chk(q, 8'h1C);
		exp_b[4] = 8'h5A;
		exp_b[5] = 8'h1C;
		pix2(4'h2);
		vchk(4'h2, 1'b0);
		$display("test_mux done");
	endtask : test_mux
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		rst_n = 1'b0;
		palette_reset = 1'b0;
		// Fields hit both 0 and F, odd bytes keep bits 7:5 clear
		for (int n = 0; n < 16; n++) begin
			exp_b[2 * n] = {~4'(n), 4'(n)};
			exp_b[2 * n + 1] = {3'b000, n[0], 4'(n + 5)};
		end
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		test_load;
		test_video;
		test_blank;
		test_select;
		test_preset;
		test_mux;
		give_verdict;
	end
	initial begin
		#100000;
		mismatches++;
		give_verdict;
	end
endmodule : test_colour_palette_lookup
